// ---- include/ctb_pkg.sv ----
package ctb_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_BUF_CFG = 8'hc0;
  localparam logic [7:0] ADDR_FQ_STATUS = 8'hc4;
  localparam logic [7:0] ADDR_ELEM_SIZE = 8'hc8;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hf0;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hf4;

  // reset values
  localparam logic [31:0] RST_BUF_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_ELEM_SIZE = 32'h0000_0000;
  localparam logic [1:0] RST_IRQ = 2'h0;

  // buffer config fields (msb is bit 0 in the printed numbering)
  localparam int CFG_MODE_BIT = 30;
  localparam int CFG_SIZE_LSB = 24;
  localparam int CFG_DEDICATED_BUFFER_COUNT_LSB = 16;
  localparam int CFG_START_LSB = 2;
  localparam logic [31:0] CFG_WR_MASK = 32'h7f3f_fffc;

  // fifo/queue status fields
  localparam int FQS_FULL_BIT = 21;
  localparam int FQS_PUT_LSB = 16;
  localparam int FQS_GET_LSB = 8;
  localparam int FQS_FREE_LSB = 0;

  // element size field
  localparam int ESC_DS_LSB = 0;
  localparam logic [31:0] ESC_WR_MASK = 32'h0000_0007;

  // interrupt status bits
  localparam int IRQ_FULL_BIT = 0;
  localparam int IRQ_PROT_BIT = 1;

  // limits and constants
  localparam logic [5:0] MAX_BUFS = 6'h20;
  localparam logic [7:0] PAD_BYTE = 8'hcc;
  localparam logic [5:0] ELEM_HDR_WORDS = 6'h02;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic mode;
    logic [5:0] size;
    logic [5:0] dedicated_buffer_count;
    logic [13:0] start;
    logic [2:0] dsc;
  } ctb_cfg_t;

  typedef struct packed {
    logic full;
    logic [4:0] put;
    logic [4:0] get;
    logic [5:0] free;
  } ctb_stat_t;

  typedef enum logic [1:0] {
    CTB_WR_IDLE = 2'b01,
    CTB_WR_RESP = 2'b10
  } ctb_wr_state_t;

endpackage : ctb_pkg

// ---- design/ctb_tx_buffer_cfg.sv ----
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module ctb_tx_buffer_cfg (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // controller side
  input wire logic prot_wr_en,
  input wire logic [31:0] pending_request_vector,
  // element address lookup for the transmit handler
  input wire logic [4:0] elem_buf_num,
  output logic [15:0] elem_word_addr,
  // data byte fetch with padding
  input wire logic byte_req,
  input wire logic [5:0] byte_idx,
  input wire logic [7:0] ram_byte,
  output logic [7:0] tx_byte,
  output logic tx_byte_valid,
  // configuration and interrupt
  output ctb_pkg::ctb_cfg_t cfg,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] buf_cfg_r;
  logic [31:0] elem_size_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [4:0] get_r;
  logic full_prev_r;
  logic [7:0] aw_addr_r;
  logic aw_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_held_r;
  ctb_pkg::ctb_wr_state_t wr_state_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] tx_byte_r;
  logic tx_byte_valid_r;
  logic [15:0] elem_word_addr_r;

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode
  logic [5:0] size_raw;
  logic [5:0] dedicated_buffer_count_raw;
  logic [5:0] size_eff;
  logic [5:0] dedicated_buffer_count_eff;
  logic queue_mode;
  logic [6:0] data_bytes;

  assign queue_mode = buf_cfg_r[ctb_pkg::CFG_MODE_BIT];
  assign size_raw = buf_cfg_r[ctb_pkg::CFG_SIZE_LSB +: 6];
  assign dedicated_buffer_count_raw = buf_cfg_r[ctb_pkg::CFG_DEDICATED_BUFFER_COUNT_LSB +: 6];
  assign size_eff = (size_raw > ctb_pkg::MAX_BUFS) ? ctb_pkg::MAX_BUFS : size_raw;
  assign dedicated_buffer_count_eff = (dedicated_buffer_count_raw > ctb_pkg::MAX_BUFS) ? ctb_pkg::MAX_BUFS : dedicated_buffer_count_raw;

  always_comb begin
    cfg.mode = queue_mode;
    cfg.size = size_eff;
    cfg.dedicated_buffer_count = dedicated_buffer_count_eff;
    cfg.start = buf_cfg_r[ctb_pkg::CFG_START_LSB +: 14];
    cfg.dsc = elem_size_r[ctb_pkg::ESC_DS_LSB +: 3];
  end

  always_comb begin
    case (cfg.dsc)
      3'h0: data_bytes = 7'h08;
      3'h1: data_bytes = 7'h0c;
      3'h2: data_bytes = 7'h10;
      3'h3: data_bytes = 7'h14;
      3'h4: data_bytes = 7'h18;
      3'h5: data_bytes = 7'h20;
      3'h6: data_bytes = 7'h30;
      default: data_bytes = 7'h40;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared region and pending-derived status
  logic [31:0] in_shared;
  logic [31:0] pend_shared;
  logic [5:0] level;
  logic [6:0] get_abs;
  logic [6:0] put_sum;
  logic [6:0] put_rel;
  logic [6:0] put_abs;
  logic [6:0] q_first_free;
  logic [4:0] get_next;
  ctb_pkg::ctb_stat_t stat;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_region
      // dedicated buffers occupy the low numbers, shared ones follow
      assign in_shared[gi] = (7'(gi) >= {1'b0, dedicated_buffer_count_eff}) &&
        (7'(gi) < ({1'b0, dedicated_buffer_count_eff} + {1'b0, size_eff}));
      assign pend_shared[gi] = in_shared[gi] & pending_request_vector[gi];
    end
  endgenerate

  always_comb begin
    level = 6'h00;
    q_first_free = 7'h00;
    for (int i = 31; i >= 0; i--) begin
      if (in_shared[i] && !pend_shared[i]) begin
        q_first_free = 7'(i);
      end
    end
    for (int i = 0; i < 32; i++) begin
      level = level + {5'h00, pend_shared[i]};
    end
  end

  assign get_abs = {1'b0, dedicated_buffer_count_eff} + {2'h0, get_r};
  assign put_sum = {2'h0, get_r} + {1'b0, level};
  assign put_rel = (put_sum >= {1'b0, size_eff}) ? (put_sum - {1'b0, size_eff}) : put_sum;
  assign put_abs = queue_mode ? q_first_free : ({1'b0, dedicated_buffer_count_eff} + put_rel);
  assign get_next = ({1'b0, get_r} + 6'h01 >= size_eff) ? 5'h00 : (get_r + 5'h01);

  always_comb begin
    stat.full = (size_eff != 6'h00) && (level == size_eff);
    stat.put = (size_eff == 6'h00) ? 5'h00 : put_abs[4:0];
    stat.get = queue_mode ? 5'h00 : get_abs[4:0];
    stat.free = queue_mode ? 6'h00 : (size_eff - level);
  end

  // get pointer walks past buffers whose request has left the pending vector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      get_r <= 5'h00;
    end else if (ce) begin
      if (queue_mode || ({1'b0, get_r} >= size_eff)) begin
        get_r <= 5'h00;
      end else if ((level != 6'h00) && !pending_request_vector[get_abs[4:0]]) begin
        get_r <= get_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  logic wr_fire;
  logic aw_hit_cfg;
  logic aw_hit_esc;
  logic aw_mapped;
  logic [31:0] wmask;
  logic prot_viol;

  assign s_axi_awready = ce && !aw_held_r && (wr_state_r == ctb_pkg::CTB_WR_IDLE);
  assign s_axi_wready = ce && !w_held_r && (wr_state_r == ctb_pkg::CTB_WR_IDLE);
  assign wr_fire = ce && aw_held_r && w_held_r && (wr_state_r == ctb_pkg::CTB_WR_IDLE);
  assign aw_hit_cfg = (aw_addr_r == ctb_pkg::ADDR_BUF_CFG);
  assign aw_hit_esc = (aw_addr_r == ctb_pkg::ADDR_ELEM_SIZE);
  assign aw_mapped = aw_hit_cfg || aw_hit_esc || (aw_addr_r == ctb_pkg::ADDR_FQ_STATUS) ||
    (aw_addr_r == ctb_pkg::ADDR_IRQ_STATUS) || (aw_addr_r == ctb_pkg::ADDR_IRQ_MASK);
  assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign prot_viol = wr_fire && (aw_hit_cfg || aw_hit_esc) && !prot_wr_en;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_r <= ctb_pkg::CTB_WR_IDLE;
      bresp_r <= ctb_pkg::RESP_OKAY;
    end else if (ce) begin
      case (wr_state_r)
        ctb_pkg::CTB_WR_IDLE: begin
          if (wr_fire) begin
            wr_state_r <= ctb_pkg::CTB_WR_RESP;
            bresp_r <= aw_mapped ? ctb_pkg::RESP_OKAY : ctb_pkg::RESP_SLVERR;
          end
        end
        ctb_pkg::CTB_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_r <= ctb_pkg::CTB_WR_IDLE;
          end
        end
        default: wr_state_r <= ctb_pkg::CTB_WR_IDLE;
      endcase
    end
  end

  assign s_axi_bvalid = (wr_state_r == ctb_pkg::CTB_WR_RESP);
  assign s_axi_bresp = bresp_r;

  // configuration registers, reserved bits stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_cfg_r <= ctb_pkg::RST_BUF_CFG;
      elem_size_r <= ctb_pkg::RST_ELEM_SIZE;
    end else if (ce && wr_fire && prot_wr_en) begin
      if (aw_hit_cfg) begin
        buf_cfg_r <= ((buf_cfg_r & ~wmask) | (w_data_r & wmask)) & ctb_pkg::CFG_WR_MASK;
      end
      if (aw_hit_esc) begin
        elem_size_r <= ((elem_size_r & ~wmask) | (w_data_r & wmask)) &
          ctb_pkg::ESC_WR_MASK;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= ctb_pkg::RST_IRQ;
    end else if (ce && wr_fire && (aw_addr_r == ctb_pkg::ADDR_IRQ_MASK) && w_strb_r[0]) begin
      irq_mask_r <= w_data_r[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  logic [7:0] ar_addr;
  logic rd_fire;
  logic stat_rd_clr;
  logic [31:0] rd_mux;
  logic rd_mapped;

  assign s_axi_arready = ce && !rvalid_r;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign ar_addr = {s_axi_araddr[7:2], 2'h0};
  assign stat_rd_clr = rd_fire && (ar_addr == ctb_pkg::ADDR_IRQ_STATUS);

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (ar_addr)
      ctb_pkg::ADDR_BUF_CFG: rd_mux = buf_cfg_r;
      ctb_pkg::ADDR_ELEM_SIZE: rd_mux = elem_size_r;
      ctb_pkg::ADDR_FQ_STATUS: begin
        rd_mux[ctb_pkg::FQS_FULL_BIT] = stat.full;
        rd_mux[ctb_pkg::FQS_PUT_LSB +: 5] = stat.put;
        rd_mux[ctb_pkg::FQS_GET_LSB +: 5] = stat.get;
        rd_mux[ctb_pkg::FQS_FREE_LSB +: 6] = stat.free;
      end
      ctb_pkg::ADDR_IRQ_STATUS: rd_mux[1:0] = irq_stat_r;
      ctb_pkg::ADDR_IRQ_MASK: rd_mux[1:0] = irq_mask_r;
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= ctb_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_mapped ? ctb_pkg::RESP_OKAY : ctb_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky events, read clears, set wins
  logic [1:0] irq_set;

  assign irq_set[ctb_pkg::IRQ_FULL_BIT] = stat.full && !full_prev_r;
  assign irq_set[ctb_pkg::IRQ_PROT_BIT] = prot_viol;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= ctb_pkg::RST_IRQ;
      full_prev_r <= 1'b0;
    end else if (ce) begin
      full_prev_r <= stat.full;
      irq_stat_r <= (stat_rd_clr ? 2'h0 : irq_stat_r) | irq_set;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // message ram element address and padded data
  logic [5:0] elem_words;
  logic [15:0] elem_offs;

  assign elem_words = ctb_pkg::ELEM_HDR_WORDS + {1'b0, data_bytes[6:2]};
  assign elem_offs = 16'({11'h000, elem_buf_num} * {10'h000, elem_words});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      elem_word_addr_r <= 16'h0000;
    end else if (ce) begin
      elem_word_addr_r <= {2'h0, cfg.start} + elem_offs;
    end
  end

  assign elem_word_addr = elem_word_addr_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_byte_r <= 8'h00;
      tx_byte_valid_r <= 1'b0;
    end else if (ce) begin
      tx_byte_valid_r <= byte_req;
      if (byte_req) begin
        tx_byte_r <= ({1'b0, byte_idx} < data_bytes) ? ram_byte : ctb_pkg::PAD_BYTE;
      end
    end
  end

  assign tx_byte = tx_byte_r;
  assign tx_byte_valid = tx_byte_valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence seq_locked_cfg_write;
    ce && wr_fire && aw_hit_cfg && !prot_wr_en;
  endsequence

  sequence seq_pad_request;
    ce && byte_req && ({1'b0, byte_idx} >= data_bytes);
  endsequence

  a_locked_cfg_kept: assert property (seq_locked_cfg_write |=> $stable(buf_cfg_r))
    else $error("config changed without protected write");
  a_pad_byte_out: assert property (seq_pad_request |=> tx_byte == 8'hcc)
    else $error("missing byte not padded");
  a_queue_get_zero: assert property (queue_mode |->
    stat.get == 5'h00 && stat.free == 6'h00)
    else $error("get or free level nonzero in queue mode");
  a_full_no_free: assert property (stat.full && !queue_mode |-> stat.free == 6'h00)
    else $error("full fifo reports free elements");
  a_size_saturate: assert property (size_raw > 6'h20 |-> cfg.size == 6'h20)
    else $error("shared size not saturated");
  a_dedicated_buffer_count_saturate: assert property (dedicated_buffer_count_raw > 6'h20 |-> cfg.dedicated_buffer_count == 6'h20)
    else $error("dedicated count not saturated");
  a_put_absolute: assert property (size_eff != 6'h00 && !queue_mode && dedicated_buffer_count_eff < 6'h20
    |-> stat.put >= dedicated_buffer_count_eff[4:0] || dedicated_buffer_count_eff == 6'h20)
    else $error("put index below dedicated buffers");
  a_size_decode_32: assert property (cfg.dsc == 3'h5 |-> data_bytes == 7'h20)
    else $error("data size code 5 not 32 bytes");
  a_full_irq_set: assert property (ce && stat.full && !full_prev_r |=> irq_stat_r[0])
    else $error("full event not latched");
  a_wr_resp_after: assert property (wr_fire |=> s_axi_bvalid &&
    (s_axi_bresp == ($past(aw_mapped) ? ctb_pkg::RESP_OKAY : ctb_pkg::RESP_SLVERR)))
    else $error("no write response after both channels");

endmodule : ctb_tx_buffer_cfg

// ---- dv/ctb_tx_handler_model.sv ----
`timescale 1ns/10ps
//////////////////////////////////////////////////
module ctb_tx_handler_model (
  // clock
  input wire logic aclk,
  // transmit handler requests
  output logic [31:0] pending_request_vector,
  output logic [4:0] elem_buf_num,
  output logic byte_req,
  output logic [5:0] byte_idx,
  // message ram data
  output logic [7:0] ram_byte
);
  logic [7:0] last_byte;
  initial begin
    pending_request_vector = 32'h0;
    elem_buf_num = 5'h0;
    byte_req = 1'b0;
    byte_idx = 6'h0;
    last_byte = 8'h00;
  end
  // ram data is valid only during a fetch, otherwise it keeps changing
  always_comb ram_byte = byte_req ? {2'h1, byte_idx} : ~last_byte;
  always @(posedge aclk) last_byte <= ram_byte;
  //////////////////////////////////////////////////
  task automatic set_pending(input logic [31:0] v);
    @(posedge aclk);
    pending_request_vector <= v;
  endtask : set_pending
  task automatic lookup(input logic [4:0] n);
    @(posedge aclk);
    elem_buf_num <= n;
  endtask : lookup
  task automatic fetch(input logic [5:0] i);
    @(posedge aclk);
    byte_idx <= i;
    byte_req <= 1'b1;
    @(posedge aclk);
    byte_req <= 1'b0;
  endtask : fetch
endmodule : ctb_tx_handler_model

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
//////////////////////////////////////////////////
module testbench;
  logic aclk, aresetn, prot_wr_en, ce;
  logic [7:0] awaddr, araddr, ram_byte, tx_byte;
  logic [31:0] wdata, s_axi_rdata, pend, rd, ex;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [4:0] elem_buf_num;
  logic [5:0] byte_idx;
  logic byte_req, tx_byte_valid, irq;
  logic [15:0] elem_word_addr;
  ctb_pkg::ctb_cfg_t cfg;
  int err_count, checks_done, seed, bytes, n, st;
  int dbytes[8] = '{8, 12, 16, 20, 24, 32, 48, 64};
  logic [31:0] steps[4] = '{32'h0, 32'h7000, 32'hffff_f000, 32'hffff_8000};
  int gets[4] = '{0, 0, 0, 3};

  ctb_tx_buffer_cfg uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(rready), .prot_wr_en(prot_wr_en),
    .pending_request_vector(pend), .elem_buf_num(elem_buf_num),
    .elem_word_addr(elem_word_addr), .byte_req(byte_req), .byte_idx(byte_idx),
    .ram_byte(ram_byte), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
    .cfg(cfg), .irq(irq));
  ctb_tx_handler_model p (.aclk(aclk), .pending_request_vector(pend),
    .elem_buf_num(elem_buf_num), .byte_req(byte_req), .byte_idx(byte_idx),
    .ram_byte(ram_byte));
  //////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      err_count++;
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (r === 2'h3) begin
      @(posedge aclk);
      if (!awvalid && !wvalid && s_axi_bvalid) r = s_axi_bresp;
      if (s_axi_awready) awvalid <= 1'b0;
      if (s_axi_wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    r = 2'h3;
    d = 32'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (r === 2'h3) begin
      @(posedge aclk);
      if (!arvalid && s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
      if (s_axi_arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d, exp);
    chk(32'(r), 32'(ctb_pkg::RESP_OKAY));
  endtask : rdchk
  task automatic irqchk(input logic exp);
    repeat (2) @(posedge aclk);
    #1;
    chk(32'(irq), 32'(exp));
  endtask : irqchk
  function automatic logic [31:0] cfg_word(int m, int sz, int nd, int s);
    return 32'(m * (1 << 30) + sz * (1 << 24) + nd * (1 << 16) + s * 4);
  endfunction : cfg_word
  // status model: level counts pending shared buffers, indices are absolute
  function automatic logic [31:0] fqs_exp(int qm, int nd, int sz, logic [31:0] pv, int g);
    int lvl;
    int put;
    lvl = 0;
    put = 0;
    for (int b = nd + sz - 1; b >= nd; b--) begin
      if (pv[b]) lvl++;
      else put = b;
    end
    if (qm == 0) put = nd + (g + lvl) % sz;
    return 32'((lvl == sz) * (1 << 21) + (put % 32) * (1 << 16)
      + (qm == 0) * ((nd + g) * (1 << 8) + sz - lvl));
  endfunction : fqs_exp
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  //////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    #100000;
    err_count++;
    conclude();
  end
  initial begin
    seed = 98116;
    err_count = 0;
    checks_done = 0;
    {aresetn, prot_wr_en, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {awaddr, araddr, wdata} = 48'h0;
    ce = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(ctb_pkg::ADDR_BUF_CFG, ctb_pkg::RST_BUF_CFG);
    rdchk(ctb_pkg::ADDR_ELEM_SIZE, ctb_pkg::RST_ELEM_SIZE);
    rdchk(ctb_pkg::ADDR_IRQ_MASK, 32'h0);
    axw(8'h10, 32'h1, resp);
    chk(32'(resp), 32'(ctb_pkg::RESP_SLVERR));
    axr(8'h10, rd, resp);
    chk(rd, 32'h0);
    chk(32'(resp), 32'(ctb_pkg::RESP_SLVERR));
    $display("test reset done");
    axw(ctb_pkg::ADDR_BUF_CFG, cfg_word(1, 4, 4, 100), resp);
    chk(32'(resp), 32'(ctb_pkg::RESP_OKAY));
    rdchk(ctb_pkg::ADDR_BUF_CFG, 32'h0);
    axw(ctb_pkg::ADDR_IRQ_MASK, 32'h2, resp);
    irqchk(1'b1);
    rdchk(ctb_pkg::ADDR_IRQ_STATUS, 32'h2);
    irqchk(1'b0);
    rdchk(ctb_pkg::ADDR_IRQ_STATUS, 32'h0);
    $display("test protect done");
    prot_wr_en <= 1'b1;
    axw(ctb_pkg::ADDR_BUF_CFG, 32'hffff_ffff, resp);
    rdchk(ctb_pkg::ADDR_BUF_CFG, ctb_pkg::CFG_WR_MASK);
    chk({cfg.mode, cfg.size, cfg.dedicated_buffer_count, cfg.start, 5'h0},
      {1'b1, 6'h20, 6'h20, 14'h3fff, 5'h0});
    axw(ctb_pkg::ADDR_ELEM_SIZE, 32'hffff_ffff, resp);
    rdchk(ctb_pkg::ADDR_ELEM_SIZE, 32'h7);
    $display("test fields done");
    for (int d = 0; d < 8; d++) begin
      st = $random(seed) & 32'h3fff;
      n = $random(seed) & 31;
      bytes = dbytes[d];
      axw(ctb_pkg::ADDR_BUF_CFG, cfg_word(0, 20, 12, st), resp);
      axw(ctb_pkg::ADDR_ELEM_SIZE, 32'(d), resp);
      p.lookup(5'(n));
      @(posedge aclk);
      #1;
      chk(32'(elem_word_addr), 32'(st + n * (2 + bytes / 4)));
      p.fetch(6'(bytes - 1));
      #1;
      chk({23'h0, tx_byte_valid, tx_byte}, {24'h1, 2'h1, 6'(bytes - 1)});
      if (bytes < 64) begin
        p.fetch(6'(bytes));
        #1;
        chk({23'h0, tx_byte_valid, tx_byte}, {24'h1, ctb_pkg::PAD_BYTE});
      end
    end
    $display("test element done");
    axw(ctb_pkg::ADDR_IRQ_MASK, 32'h1, resp);
    axw(ctb_pkg::ADDR_BUF_CFG, cfg_word(0, 20, 12, 0), resp);
    for (int s = 0; s < 4; s++) begin
      p.set_pending(steps[s] | (32'($random(seed)) & 32'hfff));
      repeat (8) @(posedge aclk);
      ex = fqs_exp(0, 12, 20, pend, gets[s]);
      rdchk(ctb_pkg::ADDR_FQ_STATUS, ex);
      if (s == 2) irqchk(1'b1);
    end
    rdchk(ctb_pkg::ADDR_IRQ_STATUS, 32'h1);
    irqchk(1'b0);
    $display("test fifo done");
    axw(ctb_pkg::ADDR_BUF_CFG, cfg_word(1, 20, 12, 0), resp);
    p.set_pending(32'h3000 | (32'($random(seed)) & 32'hfff));
    repeat (8) @(posedge aclk);
    ex = fqs_exp(1, 12, 20, pend, 0);
    rdchk(ctb_pkg::ADDR_FQ_STATUS, ex);
    $display("test queue done");
    // a fetch while the enable is low must leave the byte output frozen
    p.fetch(6'h00);
    ce <= 1'b0;
    p.fetch(6'h3f);
    #1;
    chk({23'h0, tx_byte_valid, tx_byte}, {24'h1, 8'h40});
    @(posedge aclk);
    ce <= 1'b1;
    $display("test enable done");
    conclude();
  end
endmodule : testbench
